// ===== rtl/lane_err_pkg.sv
package lane_err_pkg;
  // geometry of the receive side
  localparam int NUM_LINKS = 2;
  localparam int NUM_LANES = 8;
  localparam int NUM_ERR = 3;
  localparam int CNT_W = 8;
  localparam int NUM_CNT = NUM_LINKS * NUM_LANES * NUM_ERR;
  localparam int FIRST_SAT_LANE = 5;
  localparam int NUM_SAT_LANES = 3;
  localparam logic [CNT_W-1:0] CNT_TERMINAL = 8'hff;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  // apb addressing: register index, byte address is four times it
  localparam int APB_ADDR_W = 15;
  localparam int IDX_W = 13;
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 13'h300;
  localparam logic [IDX_W-1:0] IDX_DEC_CTRL = 13'h475;
  localparam logic [IDX_W-1:0] IDX_SAT5 = 13'h48d;
  localparam logic [IDX_W-1:0] IDX_SAT6 = 13'h48e;
  localparam logic [IDX_W-1:0] IDX_SAT7 = 13'h48f;
  localparam logic [IDX_W-1:0] IDX_STAT0 = 13'h490;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 13'h4a0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 13'h4a1;

  // field positions
  localparam int ERR_CTRL_CHAR_BIT = 2;
  localparam int ERR_CODE_GROUP_BIT = 1;
  localparam int ERR_DISPARITY_BIT = 0;
  localparam int STAT_LANE_ACTIVE_BIT = 3;
  localparam int DEC_SOFT_RST_BIT = 3;

  // values after reset
  localparam logic [2:0] SAT_RST = 3'h7;
  localparam logic LINK_PAGE_RST = 1'h0;
  localparam logic DEC_SOFT_RST_RST = 1'h0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [2:0] IRQ_STAT_RST = 3'h0;
endpackage

// ===== rtl/err_event_counter.sv
`timescale 1ns/1ns
module err_event_counter
  import lane_err_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_hold,
  input wire logic i_event,
  // state
  output logic [CNT_W-1:0] o_count,
  output logic o_terminal
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic term_r;
  logic term_nxt;
  wire at_top_w = (count_r == CNT_TERMINAL);

  // saturate under hold, otherwise wrap to zero
  assign count_nxt = i_clear ? CNT_RST :
                     (!i_event) ? count_r :
                     (at_top_w && i_hold) ? count_r : // RULE1
                     CNT_W'(count_r + 8'h01); // RULE2 RULE9
  // terminal flag sticks until the counter is cleared
  assign term_nxt = i_clear ? 1'b0 : (term_r | (count_nxt == CNT_TERMINAL)); // RULE8

  // count and flag state
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_r <= CNT_RST;
      term_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      term_r <= term_nxt;
    end
  end

  assign o_count = count_r;
  assign o_terminal = term_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_HOLD_AT_TOP: assert property ( // RULE1
    i_hold && at_top_w && !i_clear |=> count_r == CNT_TERMINAL)
    else $error("held counter left terminal count");
  AST_WRAP_TO_ZERO: assert property ( // RULE2
    !i_hold && at_top_w && i_event && !i_clear |=> count_r == CNT_RST)
    else $error("free counter did not wrap");
  AST_COUNT_STEP: assert property ( // RULE9
    i_event && !at_top_w && !i_clear |=> count_r == CNT_W'($past(count_r) + 8'h01))
    else $error("counter did not step by one");
  AST_TERM_FLAG: assert property ( // RULE8
    i_event && !i_clear && count_r == 8'hfe |=> o_terminal ##1 (o_terminal || $past(i_clear)))
    else $error("terminal flag not raised at terminal count");
endmodule // err_event_counter

// ===== rtl/lane_error_counter_hold_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// RULE1: with its hold bit set a counter stops at 0xff and keeps it until software clears it.
// RULE2: with its hold bit clear a counter wraps past 0xff and keeps counting.
// RULE3: hold bit 2 serves control character errors, bit 1 code group errors, bit 0 disparity.
// RULE4: hold and status accesses go to the link picked by the page selector at index 0x300.
// RULE5: software changes hold fields only while the decoder soft reset, index 0x475 bit 3, is set; the hold registers take writes at any time.
// RULE6: lanes 5, 6 and 7 each own a hold register at indexes 0x48d, 0x48e and 0x48f.
// RULE7: bit 3 of the lane 0 status shows lane 0 is enabled, read only, zero after reset.
// RULE8: status bits 2..0 flag per counter that 0xff was reached, same order as the hold field.
// RULE9: each counter adds one per error of its own type unless it is held at the top.
module lane_error_counter_hold_ctrl
  import lane_err_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // lane decoder events, index link*8+lane
  input wire logic [NUM_LINKS*NUM_LANES-1:0] i_err_ctrl_char,
  input wire logic [NUM_LINKS*NUM_LANES-1:0] i_err_code_group,
  input wire logic [NUM_LINKS*NUM_LANES-1:0] i_err_disparity,
  input wire logic [NUM_LINKS*NUM_LANES-1:0] i_lane_active,
  // control and interrupt
  output logic o_decoder_soft_reset,
  output logic o_irq
);
  // register index decode
  function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    reg_hit = (addr[APB_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic link_page_r;
  logic soft_rst_r;
  logic [2:0] sat_r [NUM_LINKS][NUM_SAT_LANES];
  logic [NUM_LINKS*NUM_LANES-1:0] active_r;
  logic [NUM_CNT-1:0] term_d_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_stat_nxt;
  logic [2:0] irq_mask_r;
  logic irq_r;
  logic [NUM_CNT-1:0] term_w;
  logic [NUM_CNT*CNT_W-1:0] cnt_w;

  // apb phase decode
  wire acc_w = i_psel && i_penable && !pready_r;
  wire wr_en_w = i_psel && i_penable && pready_r && i_pwrite;
  wire hit_page_w = reg_hit(i_paddr, IDX_LINK_PAGE);
  wire hit_dec_w = reg_hit(i_paddr, IDX_DEC_CTRL);
  wire hit_sat5_w = reg_hit(i_paddr, IDX_SAT5);
  wire hit_sat6_w = reg_hit(i_paddr, IDX_SAT6);
  wire hit_sat7_w = reg_hit(i_paddr, IDX_SAT7);
  wire hit_stat0_w = reg_hit(i_paddr, IDX_STAT0);
  wire hit_istat_w = reg_hit(i_paddr, IDX_IRQ_STAT);
  wire hit_imask_w = reg_hit(i_paddr, IDX_IRQ_MASK);
  wire hit_sat_w = hit_sat5_w || hit_sat6_w || hit_sat7_w;
  wire hit_any_w = hit_page_w || hit_dec_w || hit_sat_w || hit_stat0_w ||
                   hit_istat_w || hit_imask_w;
  wire [1:0] sat_slot_w = hit_sat7_w ? 2'd2 : (hit_sat6_w ? 2'd1 : 2'd0); // RULE6

  // lane 0 view of the selected link
  wire [2:0] lane0_term_w = term_w[int'(link_page_r)*NUM_LANES*NUM_ERR +: NUM_ERR]; // RULE4
  wire lane0_active_w = active_r[int'(link_page_r)*NUM_LANES]; // RULE4
  wire [7:0] stat0_w = {4'h0, lane0_active_w, lane0_term_w}; // RULE7 RULE8
  wire [2:0] sat_rd_w = sat_r[link_page_r][sat_slot_w]; // RULE4

  // read data selection
  wire [31:0] rd_data_w =
    hit_page_w ? {31'h0, link_page_r} :
    hit_dec_w ? {28'h0, soft_rst_r, 3'h0} :
    hit_sat_w ? {29'h0, sat_rd_w} :
    hit_stat0_w ? {24'h0, stat0_w} :
    hit_istat_w ? {29'h0, irq_stat_r} :
    hit_imask_w ? {29'h0, irq_mask_r} : 32'h0;

  // apb answer: one wait state, then ready
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc_w;
      if (acc_w) begin
        prdata_r <= rd_data_w;
        pslverr_r <= !hit_any_w;
      end
    end
  end

  // page selector and decoder soft reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      link_page_r <= LINK_PAGE_RST;
      soft_rst_r <= DEC_SOFT_RST_RST;
    end else begin
      if (wr_en_w && hit_page_w) link_page_r <= i_pwdata[0]; // RULE4
      if (wr_en_w && hit_dec_w) soft_rst_r <= i_pwdata[DEC_SOFT_RST_BIT]; // RULE5
    end
  end

  // hold fields, paged per link; software keeps them still outside soft reset
  generate
    for (genvar k = 0; k < NUM_LINKS; k++) begin : g_sat_link
      for (genvar s = 0; s < NUM_SAT_LANES; s++) begin : g_sat_lane
        always_ff @(posedge i_sys_clk) begin
          if (i_rst) begin
            sat_r[k][s] <= SAT_RST;
          end else if (wr_en_w && hit_sat_w && link_page_r == 1'(k) && // RULE4 RULE5
                       sat_slot_w == 2'(s)) begin // RULE6
            sat_r[k][s] <= i_pwdata[2:0];
          end
        end
      end
    end
  endgenerate

  // per lane counters; lanes below five keep the hold reset value
  generate
    for (genvar j = 0; j < NUM_LINKS*NUM_LANES; j++) begin : g_lane
      localparam int LINK = j / NUM_LANES;
      localparam int LANE = j % NUM_LANES;
      wire [2:0] ev_w;
      wire [2:0] hold_w;
      assign ev_w[ERR_CTRL_CHAR_BIT] = i_err_ctrl_char[j]; // RULE3
      assign ev_w[ERR_CODE_GROUP_BIT] = i_err_code_group[j]; // RULE3
      assign ev_w[ERR_DISPARITY_BIT] = i_err_disparity[j]; // RULE3
      if (LANE >= FIRST_SAT_LANE) begin : g_prog
        assign hold_w = sat_r[LINK][LANE-FIRST_SAT_LANE];
      end else begin : g_fixed
        assign hold_w = SAT_RST;
      end
      for (genvar e = 0; e < NUM_ERR; e++) begin : g_err
        err_event_counter u_cnt (
          .i_sys_clk(i_sys_clk),
          .i_rst(i_rst),
          .i_clear(soft_rst_r),
          .i_hold(hold_w[e]), // RULE1 RULE2 RULE3
          .i_event(ev_w[e]), // RULE9
          .o_count(cnt_w[(j*NUM_ERR+e)*CNT_W +: CNT_W]),
          .o_terminal(term_w[j*NUM_ERR+e])
        );
      end
    end
  endgenerate

  // terminal flag edges per error type
  wire [NUM_LINKS*NUM_LANES-1:0] rise_by_type [NUM_ERR];
  wire [NUM_ERR-1:0] rise_w;
  generate
    for (genvar e = 0; e < NUM_ERR; e++) begin : g_rise
      for (genvar j = 0; j < NUM_LINKS*NUM_LANES; j++) begin : g_rl
        assign rise_by_type[e][j] = term_w[j*NUM_ERR+e] && !term_d_r[j*NUM_ERR+e];
      end
      assign rise_w[e] = |rise_by_type[e];
    end
  endgenerate

  // sticky status, set wins over write-one-to-clear
  wire [2:0] irq_clr_w = (wr_en_w && hit_istat_w) ? i_pwdata[2:0] : 3'h0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | rise_w;

  // interrupt status, mask and lane enable capture
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_stat_r <= IRQ_STAT_RST;
      irq_mask_r <= IRQ_MASK_RST;
      irq_r <= 1'b0;
      term_d_r <= '0;
      active_r <= '0; // RULE7
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en_w && hit_imask_w) irq_mask_r <= i_pwdata[2:0];
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      term_d_r <= term_w;
      active_r <= i_lane_active; // RULE7
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_decoder_soft_reset = soft_rst_r;
  assign o_irq = irq_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // a write on the lane 6 hold register, and a read access of the lane 0 status
  sequence seq_sat6_write;
    wr_en_w && hit_sat6_w;
  endsequence
  sequence seq_stat0_read;
    acc_w && hit_stat0_w && !i_pwrite;
  endsequence

  AST_SAT6_STORE: assert property ( // RULE6
    seq_sat6_write |=> sat_r[$past(link_page_r)][1] == $past(i_pwdata[2:0]))
    else $error("lane 6 hold write not stored");
  AST_SAT_PAGED: assert property ( // RULE4
    seq_sat6_write |=> sat_r[!$past(link_page_r)][1] == $past(sat_r[!link_page_r][1]))
    else $error("hold write reached the other link");
  AST_STAT0_TERM: assert property ( // RULE8
    seq_stat0_read |=> o_pready && o_prdata[2:0] == $past(lane0_term_w))
    else $error("lane 0 terminal flags misread");
  AST_STAT0_ACTIVE: assert property ( // RULE7
    seq_stat0_read |=> o_prdata[STAT_LANE_ACTIVE_BIT] == $past(lane0_active_w) &&
                       o_prdata[31:4] == 28'h0)
    else $error("lane 0 active bit misread");
  AST_ACTIVE_RESET: assert property ( // RULE7
    $fell(i_rst) |-> !active_r[0] && !active_r[NUM_LANES])
    else $error("lane active not zero after reset");
  AST_CTRL_CHAR_HOLD: assert property ( // RULE3
    i_err_ctrl_char[NUM_LANES] && !soft_rst_r &&
    cnt_w[(NUM_LANES*NUM_ERR+ERR_CTRL_CHAR_BIT)*CNT_W +: CNT_W] == CNT_TERMINAL
    |=> cnt_w[(NUM_LANES*NUM_ERR+ERR_CTRL_CHAR_BIT)*CNT_W +: CNT_W] == CNT_TERMINAL)
    else $error("bit 2 does not hold the control character counter");
  AST_APB_ANSWER: assert property (
    acc_w |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle after access");
  AST_IRQ_RAISE: assert property (
    |(rise_w & irq_mask_r) |=> o_irq)
    else $error("unmasked event did not raise the interrupt");

  // access and write steps used by the register checks below
  sequence seq_any_access;
    acc_w;
  endsequence
  sequence seq_istat_write;
    wr_en_w && hit_istat_w;
  endsequence

  // apb answer shape and error response
  AST_PSLVERR_UNMAPPED: assert property (
    seq_any_access ##0 !hit_any_w |=> o_pready && o_pslverr)
    else $error("unmapped access without error response");

  AST_PSLVERR_MAPPED: assert property (
    seq_any_access ##0 hit_any_w |=> !o_pslverr)
    else $error("mapped access answered with error");

  AST_PREADY_ONLY_AFTER_ACCESS: assert property (
    !acc_w |=> !o_pready)
    else $error("ready without a pending access");

  AST_PRDATA_STEADY: assert property (
    !acc_w |=> $stable(o_prdata))
    else $error("read data moved without an access");

  AST_UNMAPPED_READ_ZERO: assert property (
    seq_any_access ##0 !hit_any_w |=> o_prdata == 32'h0)
    else $error("unmapped read not zero");

  // page selector and decoder soft reset
  AST_PAGE_STORE: assert property ( // RULE4
    wr_en_w && hit_page_w |=> link_page_r == $past(i_pwdata[0]))
    else $error("page write not stored");

  AST_PAGE_KEPT: assert property ( // RULE4
    !(wr_en_w && hit_page_w) |=> $stable(link_page_r))
    else $error("page changed without a write");

  AST_PAGE_READ: assert property ( // RULE4
    acc_w && hit_page_w |=> o_prdata == {31'h0, $past(link_page_r)})
    else $error("page read wrong");

  AST_SOFT_RST_STORE: assert property (
    wr_en_w && hit_dec_w |=> o_decoder_soft_reset == $past(i_pwdata[DEC_SOFT_RST_BIT]))
    else $error("soft reset write not stored");

  AST_SOFT_RST_KEPT: assert property (
    !(wr_en_w && hit_dec_w) |=> $stable(o_decoder_soft_reset))
    else $error("soft reset changed without a write");

  // hold registers of lanes 5 and 7, paging and readback
  AST_SAT5_STORE: assert property ( // RULE6
    wr_en_w && hit_sat5_w |=> sat_r[$past(link_page_r)][0] == $past(i_pwdata[2:0]))
    else $error("lane 5 hold write not stored");

  AST_SAT7_STORE: assert property ( // RULE6
    wr_en_w && hit_sat7_w |=> sat_r[$past(link_page_r)][2] == $past(i_pwdata[2:0]))
    else $error("lane 7 hold write not stored");

  AST_SAT_KEPT: assert property ( // RULE4
    !(wr_en_w && hit_sat_w) |=> $stable(sat_r[0][0]) && $stable(sat_r[1][2]))
    else $error("hold field changed without a write");

  AST_SAT_READ: assert property ( // RULE4
    acc_w && hit_sat_w && !i_pwrite |=> o_prdata == {29'h0, $past(sat_rd_w)})
    else $error("hold field read wrong");

  // lane 0 status is read only and paged
  AST_STAT0_READONLY: assert property ( // RULE7
    acc_w && hit_stat0_w && i_pwrite |=> !o_pslverr)
    else $error("status write answered with error");

  AST_STAT0_LINK1: assert property ( // RULE4
    acc_w && hit_stat0_w && link_page_r |=>
    o_prdata[2:0] == $past(term_w[NUM_LANES*NUM_ERR +: NUM_ERR]))
    else $error("link 1 lane 0 flags misread");

  AST_ACTIVE_FOLLOW: assert property ( // RULE7
    1'b1 |=> active_r == $past(i_lane_active))
    else $error("lane active capture lags");

  // counters and terminal flags under soft reset
  AST_CLEAR_COUNTS: assert property ( // RULE1
    soft_rst_r |=> cnt_w == '0 && term_w == '0)
    else $error("soft reset did not clear counters");

  AST_TERM_STICKY: assert property ( // RULE8
    !soft_rst_r |=> (term_w & $past(term_w)) == $past(term_w))
    else $error("terminal flag dropped without soft reset");

  // interrupt status, mask and level
  AST_IRQ_STAT_SET: assert property (
    |rise_w |=> (irq_stat_r & $past(rise_w)) == $past(rise_w))
    else $error("status bit not set by terminal event");

  AST_IRQ_W1C: assert property (
    seq_istat_write ##0 (rise_w & i_pwdata[2:0]) == 3'h0 |=>
    (irq_stat_r & $past(i_pwdata[2:0])) == 3'h0)
    else $error("status bit not cleared by writing one");

  AST_IRQ_STAT_KEEP: assert property (
    !(wr_en_w && hit_istat_w) |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
    else $error("status bit lost without a clear");

  AST_MASK_STORE: assert property (
    wr_en_w && hit_imask_w |=> irq_mask_r == $past(i_pwdata[2:0]))
    else $error("mask write not stored");

  AST_MASK_KEPT: assert property (
    !(wr_en_w && hit_imask_w) |=> $stable(irq_mask_r))
    else $error("mask changed without a write");

  AST_IRQ_LEVEL: assert property (
    o_irq == |(irq_stat_r & $past(irq_mask_r)))
    else $error("interrupt level does not follow status and mask");

  AST_IRQ_LOW_NONE: assert property (
    irq_stat_r == 3'h0 |-> !o_irq)
    else $error("interrupt high with empty status");
endmodule // lane_error_counter_hold_ctrl

// ===== tb/lane_err_src.sv
`timescale 1ns/1ns
// far-end transmitter stand-in: emits a burst of one-cycle error pulses
module lane_err_src
  import lane_err_pkg::*;
(
  // clock
  input wire logic i_sys_clk,
  // burst request
  input wire logic i_go,
  input wire logic [1:0] i_kind,
  input wire logic [3:0] i_bit,
  input wire logic [8:0] i_num,
  // lane error pulses
  output logic o_busy,
  output logic [15:0] o_ctrl_char = 16'h0,
  output logic [15:0] o_code_group = 16'h0,
  output logic [15:0] o_disparity = 16'h0
);
  logic [8:0] left = 9'h0;
  wire [15:0] one_hot = 16'h1 << i_bit;
  assign o_busy = (left != 9'h0);
  // one pulse per cycle, on the lane and kind asked for
  always @(posedge i_sys_clk) begin
    o_ctrl_char <= (o_busy && i_kind == 2'h2) ? one_hot : 16'h0;
    o_code_group <= (o_busy && i_kind == 2'h1) ? one_hot : 16'h0;
    o_disparity <= (o_busy && i_kind == 2'h0) ? one_hot : 16'h0;
    if (o_busy) begin
      left <= left - 9'h1;
    end else if (i_go) begin
      left <= i_num;
    end
  end
endmodule // lane_err_src

// ===== tb/lane_error_counter_hold_ctrl_tb_top.sv
`timescale 1ns/1ns
module lane_error_counter_hold_ctrl_tb_top;
  import lane_err_pkg::*;
  typedef struct {logic [12:0] ix; logic [7:0] rv; logic [7:0] wd; logic [7:0] ev; logic er;} row_s;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
  logic [14:0] paddr = 15'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sr, irq, busy, e;
  logic [15:0] ecc, ecg, ed, act = 16'h0;
  logic [1:0] kind = 2'h0;
  logic [3:0] lbit = 4'h0;
  logic [8:0] num = 9'h0;
  int err_total = 0, total_checks = 0;
  row_s rows[7] = '{'{13'h48d, 8'h07, 8'hff, 8'h07, 1'b0}, '{13'h48e, 8'h07, 8'h02, 8'h02, 1'b0},
    '{13'h48f, 8'h07, 8'h05, 8'h05, 1'b0}, '{13'h490, 8'h00, 8'hff, 8'h00, 1'b0},
    '{13'h4a1, 8'h00, 8'h02, 8'h02, 1'b0}, '{13'h300, 8'h00, 8'h00, 8'h00, 1'b0},
    '{13'h123, 8'h00, 8'h01, 8'h00, 1'b1}};
  // clock
  initial begin
    forever #20 clk = ~clk;
  end
  lane_error_counter_hold_ctrl lane_error_counter_hold_ctrl_i (.i_sys_clk(clk), .i_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_err_ctrl_char(ecc),
    .i_err_code_group(ecg), .i_err_disparity(ed), .i_lane_active(act),
    .o_decoder_soft_reset(sr), .o_irq(irq));
  lane_err_src lane_err_src_i (.i_sys_clk(clk), .i_go(go), .i_kind(kind), .i_bit(lbit),
    .i_num(num), .o_busy(busy), .o_ctrl_char(ecc), .o_code_group(ecg), .o_disparity(ed));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a limit
  task automatic xfer(input logic w, input logic [12:0] ix, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    if (n >= 50) err_total++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rchk(input logic [12:0] ix, input logic [7:0] exp);
    xfer(1'b0, ix, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  // burst of error pulses from the far end, then let flags settle
  task automatic send(input logic [1:0] k, input logic [3:0] b, input logic [8:0] cnt);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    lbit <= b;
    num <= cnt;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 600);
    repeat (4) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({pready, pslverr, irq, sr}, 32'h0);
    // reset value, write, read back, error flag
    foreach (rows[i]) begin
      rchk(rows[i].ix, rows[i].rv);
      xfer(1'b1, rows[i].ix, {24'h0, rows[i].wd});
      rchk(rows[i].ix, rows[i].ev);
      chk(e, rows[i].er);
    end
    // paging of link 1
    act <= 16'h0001;
    xfer(1'b1, 13'h300, 32'h1);
    rchk(13'h48e, 8'h07);
    rchk(13'h490, 8'h00);
    xfer(1'b1, 13'h300, 32'h0);
    rchk(13'h490, 8'h08);
    rchk(13'h48e, 8'h02);
    // lane 5 holds cleared under soft reset, then wrap-mode burst
    xfer(1'b1, 13'h475, 32'h8);
    @(posedge clk);
    chk(sr, 1'b1);
    xfer(1'b1, 13'h48d, 32'h0);
    xfer(1'b1, 13'h475, 32'h0);
    send(2'h0, 4'h5, 9'd255);
    rchk(13'h4a0, 8'h01);
    chk(irq, 1'b0);
    // lane 0 code group counter one short, then at terminal
    send(2'h1, 4'h0, 9'd254);
    rchk(13'h490, 8'h08);
    send(2'h1, 4'h0, 9'd1);
    rchk(13'h490, 8'h0a);
    rchk(13'h4a0, 8'h03);
    chk(irq, 1'b1);
    xfer(1'b1, 13'h4a0, 32'h2);
    rchk(13'h4a0, 8'h01);
    chk(irq, 1'b0);
    // soft reset clears terminal flags
    xfer(1'b1, 13'h475, 32'h8);
    xfer(1'b1, 13'h475, 32'h0);
    rchk(13'h490, 8'h08);
    // control char errors on link 1 lane 0
    xfer(1'b1, 13'h300, 32'h1);
    send(2'h2, 4'h8, 9'd256);
    rchk(13'h490, 8'h04);
    xfer(1'b1, 13'h300, 32'h0);
    rchk(13'h490, 8'h08);
    end_of_test();
  end
endmodule // lane_error_counter_hold_ctrl_tb_top
